// [design/trailer_pkg.sv]
// Package with register map, field layout and constants for the trailer builder
package trailer_pkg;
  localparam int TRAILER_WORDS = 9;
  localparam logic [1:0] WID_BODY = 2'b10;
  localparam logic [1:0] WID_LAST = 2'b11;
  localparam int CODE_LSB = 26;
  localparam int VALUE_W = 26;
  localparam logic [3:0] CODE_LENGTH = 4'h0;
  localparam logic [3:0] CODE_ERR_BRANCH = 4'h1;
  localparam logic [3:0] CODE_RDO_ERR = 4'h2;
  localparam logic [3:0] CODE_MISMATCH = 4'h3;
  localparam logic [3:0] CODE_ACT_A = 4'h4;
  localparam logic [3:0] CODE_ACT_B = 4'h5;
  localparam logic [3:0] CODE_CFG_ONE = 4'h6;
  localparam logic [3:0] CODE_CFG_TWO = 4'h7;
  localparam logic [3:0] CODE_ID = 4'h8;
  // Printed offsets are word indices; byte address is four times the index
  localparam logic [15:0] IDX_CFG_ONE = 16'h5104;
  localparam logic [15:0] IDX_CFG_TWO = 16'h5105;
  localparam logic [15:0] IDX_ACT_A = 16'h5110;
  localparam logic [15:0] IDX_ACT_B = 16'h5111;
  localparam logic [15:0] IDX_STATUS = 16'h5112;
  localparam logic [15:0] IDX_UNIT_ADDR = 16'h5113;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] ACT_RESET = 32'h0000_0000;
  localparam logic [8:0] UNIT_ADDR_RESET = 9'h000;
  localparam logic [9:0] FW_VERSION = 10'h001; // Arbitrary value
  localparam logic [6:0] TRAILER_LEN = 7'h09;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } trl_state_t;
endpackage : trailer_pkg

// [design/readout_trailer_builder.sv]
// Trailer word builder for event readout with APB configuration registers
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module readout_trailer_builder
  import trailer_pkg::*;
#(
  parameter int ADDR_CNT_W = 12,
  parameter int BLK_CNT_W = 13
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event control from the readout state machine
  input wire logic event_start,
  input wire logic payload_done,
  input wire logic [25:0] payload_length,
  // Front-end card error status per branch
  input wire logic [19:0] branch_a_card_error_status,
  input wire logic [19:0] branch_b_card_error_status,
  // Readout fault inputs (levels, sampled during the event)
  input wire logic receiver_ready_error,
  input wire logic scan_event_length_error,
  input wire logic [4:0] event_length_readout_error,
  // Channel trailer check
  input wire logic data_strobe,
  input wire logic channel_select,
  input wire logic [11:0] channel_addressed,
  input wire logic channel_trailer_valid,
  input wire logic [11:0] channel_trailer_addr,
  input wire logic [9:0] channel_trailer_count,
  // Trailer stream to the link source interface
  output logic [31:0] trailer_data,
  output logic trailer_valid,
  input wire logic trailer_ready,
  output logic trailer_busy
);

  logic [31:0] datapath_config_one;
  logic [31:0] datapath_config_two;
  logic [31:0] act_list_a;
  logic [31:0] act_list_b;
  logic [8:0] unit_addr;
  logic [ADDR_CNT_W-1:0] addr_mismatch_cnt;
  logic [BLK_CNT_W-1:0] blk_mismatch_cnt;
  logic [9:0] strobe_cnt;
  logic [11:0] last_channel;
  logic addr_flag;
  logic blk_flag;
  logic ready_flag;
  logic scan_flag;
  logic [4:0] evlen_flag;
  trl_state_t state;
  logic [3:0] word_idx;
  logic [3:0] next_word_idx;
  logic [25:0] word_value;
  logic [31:0] word;
  logic wr_en;
  logic rd_en;
  logic [15:0] word_addr;
  logic addr_ok;
  logic word_accept;

  // APB decode: zero-wait slave, unaligned or unmapped answers pslverr
  assign word_addr = paddr[17:2];
  assign pready = 1'b1;
  assign addr_ok = (paddr[1:0] == 2'b00) && ((word_addr == IDX_CFG_ONE) ||
      (word_addr == IDX_CFG_TWO) || (word_addr == IDX_ACT_A) || (word_addr == IDX_ACT_B) ||
      (word_addr == IDX_STATUS) || (word_addr == IDX_UNIT_ADDR));
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      datapath_config_one <= CFG_RESET;
      datapath_config_two <= CFG_RESET;
      act_list_a <= ACT_RESET;
      act_list_b <= ACT_RESET;
      unit_addr <= UNIT_ADDR_RESET;
    end else if (wr_en) begin
      case (word_addr)
        IDX_CFG_ONE: datapath_config_one <= pwdata;
        IDX_CFG_TWO: datapath_config_two <= pwdata;
        IDX_ACT_A: act_list_a <= pwdata;
        IDX_ACT_B: act_list_b <= pwdata;
        IDX_UNIT_ADDR: unit_addr <= pwdata[8:0];
        default: begin
        end
      endcase
    end
  end

  // Read data registered in the setup cycle, valid in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (word_addr)
        IDX_CFG_ONE: prdata <= datapath_config_one;
        IDX_CFG_TWO: prdata <= datapath_config_two;
        IDX_ACT_A: prdata <= act_list_a;
        IDX_ACT_B: prdata <= act_list_b;
        IDX_UNIT_ADDR: prdata <= {23'h00_0000, unit_addr};
        IDX_STATUS: prdata <= {blk_mismatch_cnt, addr_mismatch_cnt, 2'b00, state == ST_SEND,
            word_idx};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Strobe count per channel and last addressed channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_cnt <= 10'h000;
      last_channel <= 12'h000;
    end else if (event_start || channel_trailer_valid) begin
      strobe_cnt <= 10'h000;
    end else begin
      if (data_strobe) begin
        strobe_cnt <= strobe_cnt + 10'h001;
      end
      if (channel_select) begin
        last_channel <= channel_addressed;
      end
    end
  end

  // Mismatch counters and flags cleared per event; sticky readout error flags reloaded from the fault inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_mismatch_cnt <= '0;
      blk_mismatch_cnt <= '0;
      addr_flag <= 1'b0;
      blk_flag <= 1'b0;
      ready_flag <= 1'b0;
      scan_flag <= 1'b0;
      evlen_flag <= 5'h00;
    end else if (event_start) begin
      addr_mismatch_cnt <= '0;
      blk_mismatch_cnt <= '0;
      addr_flag <= 1'b0;
      blk_flag <= 1'b0;
      ready_flag <= receiver_ready_error;
      scan_flag <= scan_event_length_error;
      evlen_flag <= event_length_readout_error;
    end else begin
      if (channel_trailer_valid && channel_trailer_addr != last_channel) begin
        addr_mismatch_cnt <= addr_mismatch_cnt + ADDR_CNT_W'(1);
        addr_flag <= 1'b1;
      end
      if (channel_trailer_valid && channel_trailer_count != strobe_cnt) begin
        blk_mismatch_cnt <= blk_mismatch_cnt + BLK_CNT_W'(1);
        blk_flag <= 1'b1;
      end
      ready_flag <= ready_flag | receiver_ready_error;
      scan_flag <= scan_flag | scan_event_length_error;
      evlen_flag <= evlen_flag | event_length_readout_error;
    end
  end

  // Value field of the word that stands after this edge
  always_comb begin
    word_value = 26'h000_0000;
    case (next_word_idx)
      CODE_LENGTH: word_value = payload_length;
      CODE_ERR_BRANCH: word_value = {branch_a_card_error_status[19:7],
          branch_b_card_error_status[19:7]};
      CODE_RDO_ERR: word_value = {17'h0_0000, blk_flag, addr_flag, ready_flag, scan_flag,
          evlen_flag};
      CODE_MISMATCH: word_value = {1'b0, blk_mismatch_cnt[12:0],
          addr_mismatch_cnt[11:0]};
      CODE_ACT_A: word_value = act_list_a[25:0];
      CODE_ACT_B: word_value = act_list_b[25:0];
      CODE_CFG_ONE: word_value = datapath_config_one[25:0];
      CODE_CFG_TWO: word_value = datapath_config_two[25:0];
      CODE_ID: word_value = {FW_VERSION, unit_addr, TRAILER_LEN};
      default: word_value = 26'h000_0000;
    endcase
  end

  assign word = {(next_word_idx == CODE_ID) ? WID_LAST : WID_BODY, next_word_idx,
      word_value};
  assign word_accept = trailer_valid && trailer_ready;
  assign next_word_idx = word_accept ? word_idx + 4'h1 : word_idx;

  // Sequencer: one word per accepted cycle, ascending code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      word_idx <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          word_idx <= 4'h0;
          if (payload_done) begin
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          word_idx <= next_word_idx;
          if (word_accept && word_idx == CODE_ID) begin
            state <= ST_IDLE;
            word_idx <= 4'h0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Output word register, preloaded with the next word as one is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trailer_data <= 32'h0000_0000;
    end else begin
      trailer_data <= word;
    end
  end

  assign trailer_valid = (state == ST_SEND);
  assign trailer_busy = (state == ST_SEND);

  // Assertions
  property p_code_field;
    @(posedge pclk) disable iff (!presetn)
    trailer_valid |-> trailer_data[29:26] == word_idx;
  endproperty
  a_code_field: assert property (p_code_field) else $error("code field wrong");

  property p_nine_words;
    @(posedge pclk) disable iff (!presetn)
    (word_accept && word_idx == CODE_ID) |=> state == ST_IDLE;
  endproperty
  a_nine_words: assert property (p_nine_words) else $error("trailer not ended");

  property p_body_id;
    @(posedge pclk) disable iff (!presetn)
    (trailer_valid && word_idx != CODE_ID) |-> trailer_data[31:30] == WID_BODY;
  endproperty
  a_body_id: assert property (p_body_id) else $error("body word id wrong");

  property p_last_id;
    @(posedge pclk) disable iff (!presetn)
    (trailer_valid && word_idx == CODE_ID) |-> trailer_data[31:30] == WID_LAST &&
        trailer_data[6:0] == TRAILER_LEN && trailer_data[25:16] == FW_VERSION;
  endproperty
  a_last_id: assert property (p_last_id) else $error("last word wrong");

  property p_ascend;
    @(posedge pclk) disable iff (!presetn)
    (word_accept && word_idx != CODE_ID) |=> word_idx == $past(word_idx) + 4'h1;
  endproperty
  a_ascend: assert property (p_ascend) else $error("codes not ascending");

  property p_addr_count;
    @(posedge pclk) disable iff (!presetn)
    (!event_start && channel_trailer_valid && channel_trailer_addr != last_channel)
        |=> addr_mismatch_cnt == $past(addr_mismatch_cnt) + ADDR_CNT_W'(1) && addr_flag;
  endproperty
  a_addr_count: assert property (p_addr_count) else $error("address count missed");

  property p_blk_count;
    @(posedge pclk) disable iff (!presetn)
    (!event_start && channel_trailer_valid && channel_trailer_count == strobe_cnt)
        |=> blk_mismatch_cnt == $past(blk_mismatch_cnt);
  endproperty
  a_blk_count: assert property (p_blk_count) else $error("false block mismatch");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    event_start |=> addr_mismatch_cnt == '0 && blk_mismatch_cnt == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("counters not cleared");

  property p_cfg_copy;
    @(posedge pclk) disable iff (!presetn)
    (trailer_valid && word_idx == CODE_CFG_TWO) |-> trailer_data[25:0] ==
        $past(datapath_config_two[25:0]);
  endproperty
  a_cfg_copy: assert property (p_cfg_copy) else $error("config copy wrong");

  property p_length_word;
    @(posedge pclk) disable iff (!presetn)
    (trailer_valid && word_idx == CODE_LENGTH) |-> trailer_data[25:0] == $past(payload_length);
  endproperty
  a_length_word: assert property (p_length_word) else $error("length word wrong");

  property p_branch_word;
    @(posedge pclk) disable iff (!presetn)
    (trailer_valid && word_idx == CODE_ERR_BRANCH) |-> trailer_data[25:0] ==
        {$past(branch_a_card_error_status[19:7]), $past(branch_b_card_error_status[19:7])};
  endproperty
  a_branch_word: assert property (p_branch_word) else $error("branch word wrong");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
    !event_start |=> (scan_flag || !$past(scan_event_length_error)) &&
        (ready_flag || !$past(receiver_ready_error)) &&
        ((evlen_flag & $past(event_length_readout_error)) == $past(event_length_readout_error));
  endproperty
  a_sticky: assert property (p_sticky) else $error("readout error flag lost");

  property p_count_word;
    @(posedge pclk) disable iff (!presetn)
    (trailer_valid && word_idx == CODE_MISMATCH) |-> trailer_data[11:0] ==
        $past(addr_mismatch_cnt[11:0]) && trailer_data[24:12] == $past(blk_mismatch_cnt[12:0]);
  endproperty
  a_count_word: assert property (p_count_word) else $error("count word wrong");

  property p_blk_hit;
    @(posedge pclk) disable iff (!presetn)
    (!event_start && channel_trailer_valid && channel_trailer_count != strobe_cnt)
        |=> blk_mismatch_cnt == $past(blk_mismatch_cnt) + BLK_CNT_W'(1) && blk_flag;
  endproperty
  a_blk_hit: assert property (p_blk_hit) else $error("block mismatch missed");

  property p_act_lists;
    @(posedge pclk) disable iff (!presetn)
    (trailer_valid && (word_idx == CODE_ACT_A || word_idx == CODE_ACT_B)) |->
        trailer_data[25:0] == (word_idx == CODE_ACT_A ? $past(act_list_a[25:0]) :
        $past(act_list_b[25:0]));
  endproperty
  a_act_lists: assert property (p_act_lists) else $error("active list wrong");

  property p_cfg_write;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && paddr == {IDX_CFG_ONE, 2'b00}) |=>
        datapath_config_one == $past(pwdata);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_unit_id;
    @(posedge pclk) disable iff (!presetn)
    (trailer_valid && word_idx == CODE_ID) |-> trailer_data[15:7] == $past(unit_addr) &&
        trailer_data[6:0] == 7'(TRAILER_WORDS);
  endproperty
  a_unit_id: assert property (p_unit_id) else $error("identity word wrong");

  property p_throughput;
    @(posedge pclk) disable iff (!presetn)
    (word_accept && word_idx != CODE_ID) |=> trailer_valid;
  endproperty
  a_throughput: assert property (p_throughput) else $error("bubble in trailer");

  c_full_trailer: cover property (@(posedge pclk) disable iff (!presetn)
      word_accept && word_idx == CODE_ID);
  c_stall: cover property (@(posedge pclk) disable iff (!presetn)
      trailer_valid && !trailer_ready);
  c_mismatch: cover property (@(posedge pclk) disable iff (!presetn)
      channel_trailer_valid && channel_trailer_addr != last_channel);
  c_block_mismatch: cover property (@(posedge pclk) disable iff (!presetn)
      channel_trailer_valid && channel_trailer_count != strobe_cnt);
  c_back_to_back: cover property (@(posedge pclk) disable iff (!presetn)
      word_accept && $past(word_accept));

endmodule : readout_trailer_builder
`default_nettype wire

// [tb/link_sink_model.sv]
// Behavioural model of the link source interface that takes trailer words
`timescale 1ns/10ps
`default_nettype none
module link_sink_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Trailer stream
  input wire logic [31:0] trailer_data,
  input wire logic trailer_valid,
  output logic trailer_ready,
  // Control and capture
  input wire logic slow,
  input wire logic clear,
  output logic [31:0] words [0:8],
  output logic [3:0] n_words
);
  // Slow mode stalls every other cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trailer_ready <= 1'b0;
    end else begin
      trailer_ready <= slow ? ~trailer_ready : 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_words <= 4'h0;
    end else if (clear) begin
      n_words <= 4'h0;
    end else if (trailer_valid && trailer_ready && n_words < 4'h9) begin
      words[n_words] <= trailer_data;
      n_words <= n_words + 4'h1;
    end
  end
endmodule : link_sink_model
`default_nettype wire

// [tb/tb.sv]
// Testbench for the trailer builder: registers and two events
`timescale 1ns/10ps
`default_nettype none
module tb;
  import trailer_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd, trailer_data;
  logic event_start, payload_done, rdy_err, scan_err, data_strobe, channel_select;
  logic [25:0] payload_length;
  logic [25:0] ev [0:8];
  logic [19:0] err_a, err_b;
  logic [4:0] evlen;
  logic channel_trailer_valid, trailer_valid, trailer_ready, trailer_busy, slow, clear;
  logic [11:0] channel_addressed, channel_trailer_addr;
  logic [9:0] channel_trailer_count;
  logic [31:0] words [0:8];
  logic [3:0] n_words;
  logic [15:0] regs [0:4] = '{IDX_CFG_ONE, IDX_CFG_TWO, IDX_ACT_A, IDX_ACT_B, IDX_UNIT_ADDR};
  logic [31:0] vals [0:4] = '{32'h0123_4567, 32'h0000_001F, 32'h0155_5555, 32'h02AA_AAAA,
    32'h0000_018D};
  int n_mismatch = 0;
  int num_checks = 0;

  readout_trailer_builder readout_trailer_builder_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_start(event_start),
    .payload_done(payload_done), .payload_length(payload_length),
    .branch_a_card_error_status(err_a), .branch_b_card_error_status(err_b),
    .receiver_ready_error(rdy_err), .scan_event_length_error(scan_err),
    .event_length_readout_error(evlen), .data_strobe(data_strobe),
    .channel_select(channel_select), .channel_addressed(channel_addressed),
    .channel_trailer_valid(channel_trailer_valid), .channel_trailer_addr(channel_trailer_addr),
    .channel_trailer_count(channel_trailer_count), .trailer_data(trailer_data),
    .trailer_valid(trailer_valid), .trailer_ready(trailer_ready), .trailer_busy(trailer_busy));
  link_sink_model link_sink_model_i (.pclk(pclk), .presetn(presetn),
    .trailer_data(trailer_data), .trailer_valid(trailer_valid), .trailer_ready(trailer_ready),
    .slow(slow), .clear(clear), .words(words), .n_words(n_words));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic start_event(input logic [19:0] a, input logic [19:0] b, input logic e);
    @(posedge pclk);
    err_a <= a;
    err_b <= b;
    event_start <= 1'b1;
    @(posedge pclk);
    event_start <= 1'b0;
    rdy_err <= e;
    scan_err <= e;
    evlen <= e ? 5'h11 : 5'h00;
    @(posedge pclk);
    rdy_err <= 1'b0;
    scan_err <= 1'b0;
    evlen <= 5'h00;
  endtask : start_event

  task automatic chan(input logic [11:0] sel, input int ns, input logic [11:0] ta,
                      input logic [9:0] tc);
    @(posedge pclk);
    channel_select <= 1'b1;
    channel_addressed <= sel;
    @(posedge pclk);
    channel_select <= 1'b0;
    repeat (ns) begin
      data_strobe <= 1'b1;
      @(posedge pclk);
    end
    data_strobe <= 1'b0;
    channel_trailer_valid <= 1'b1;
    channel_trailer_addr <= ta;
    channel_trailer_count <= tc;
    @(posedge pclk);
    channel_trailer_valid <= 1'b0;
  endtask : chan

  task automatic trailer(input logic slw);
    int t;
    slow <= slw;
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    payload_done <= 1'b1;
    @(posedge pclk);
    payload_done <= 1'b0;
    t = 0;
    while (n_words !== 4'h9 && t < 200) begin
      @(posedge pclk);
      t++;
    end
    @(posedge pclk);
    chk({28'h000_0000, n_words}, 32'h0000_0009);
    chk({31'h0, trailer_busy}, 32'h0);
    ev[1] = {err_a[19:7], err_b[19:7]};
    for (int i = 0; i < 9; i++) begin
      chk(words[i], {(i == 8) ? 2'b11 : 2'b10, 4'(i), ev[i]});
    end
  endtask : trailer

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    {presetn, psel, penable, pwrite, event_start, payload_done, rdy_err, scan_err} = '0;
    {data_strobe, channel_select, channel_trailer_valid, slow, clear} = '0;
    {paddr, pwdata, payload_length, err_a, err_b, evlen} = '0;
    {channel_addressed, channel_trailer_addr, channel_trailer_count} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk({30'h0, pready, pslverr}, 32'h0000_0002);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, regs[i], 32'h0, rd, er);
      chk(rd, 32'h0);
      apb(1'b1, regs[i], vals[i], rd, er);
      apb(1'b0, regs[i], 32'h0, rd, er);
      chk(rd, vals[i]);
      chk({31'h0, er}, 32'h0);
    end
    apb(1'b1, 16'h5120, 32'hFFFF_FFFF, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 16'h5120, 32'h0, rd, er);
    chk(rd, 32'h0);
    $display("Test registers done");
    // Event with every fault and both kinds of mismatch
    payload_length <= 26'h000_0123;
    start_event(20'hAAAAA, 20'h55555, 1'b1);
    chan(12'h005, 3, 12'h006, 10'd3);
    chan(12'h007, 2, 12'h007, 10'd4);
    ev = '{26'h000_0123, 26'h0, {17'h0, 4'hF, 5'h11}, {1'b0, 13'h1, 12'h1},
      vals[2][25:0], vals[3][25:0], vals[0][25:0], vals[1][25:0],
      {FW_VERSION, 9'h18D, 7'd9}};
    trailer(1'b1);
    $display("Test faulty event done");
    // Clean event: flags and counters start over
    payload_length <= 26'h3FF_FFFF;
    start_event(20'h55555, 20'hAAAAA, 1'b0);
    chan(12'h002, 1, 12'h002, 10'd1);
    ev[0] = 26'h3FF_FFFF;
    ev[2] = 26'h0;
    ev[3] = 26'h0;
    trailer(1'b0);
    $display("Test clean event done");
    end_of_test();
  end

  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
